//--- adcc_map.svh
// register map, field positions, reset values and timing of the converter
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define ADCC_IDX_RES_HIGH 10'h01E
`define ADCC_IDX_CTRL0 10'h01F
`define ADCC_IDX_PIN_SEL 10'h091
`define ADCC_IDX_RES_LOW 10'h09E
`define ADCC_IDX_CTRL1 10'h09F
`define ADCC_IDX_PFLAG 10'h00C
`define ADCC_IDX_PEN 10'h08C
`define ADCC_IDX_ICTL 10'h00B

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ADCC_C0_FMT 7
`define ADCC_C0_REFH 6
`define ADCC_C0_REFL 5
`define ADCC_C0_CHS_HI 4
`define ADCC_C0_CHS_LO 2
`define ADCC_C0_GO 1
`define ADCC_C0_ON 0
`define ADCC_C1_CS_HI 6
`define ADCC_C1_CS_LO 4
`define ADCC_PF_DONE 6
`define ADCC_PE_DONE 6
`define ADCC_IC_GIE 7
`define ADCC_IC_PERIPHERAL_IRQ_ENABLE 6

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define ADCC_C0_RST 8'h00
`define ADCC_C1_RST 3'h0
`define ADCC_PIN_SEL_RST 8'hFF
`define ADCC_CS_RC 2'h3
`define ADCC_RES_BITS 10
`define ADCC_RIGHT_PAD 6'h00
`define ADCC_LEFT_PAD 6'h00

// ----------------------------------------------------------------------
// timing: one instruction cycle is four system clocks
// ----------------------------------------------------------------------
`define ADCC_CLK_NS 100
`define ADCC_INSTR_NS 400
`define ADCC_INSTR_CLKS ((`ADCC_INSTR_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)

`endif

//--- adcc_pkg.sv
// types shared by the converter control modules
package adcc_pkg;

    // ------------------------------------------------------------------
    // control sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {ADCC_IDLE, ADCC_HOLD, ADCC_CONV} adcc_state_t;

    typedef struct packed {
        adcc_state_t state;
        logic [7:0] ctrl0;
        logic [2:0] clkSel;
        logic [7:0] pinSel;
        logic doneFlag;
        logic irqEn;
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic powerDown;
        logic [2:0] hold;
        logic cmpMeta;
        logic cmpSync;
    } adcc_ctrl_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } adcc_result_t;

    // ------------------------------------------------------------------
    // conversion clock and approximation register
    // ------------------------------------------------------------------
    typedef struct packed {
        logic rcMeta;
        logic rcSync;
        logic rcLast;
        logic [6:0] cnt;
    } adcc_tad_t;

    typedef struct packed {
        logic busy;
        logic [9:0] mask;
        logic [9:0] code;
    } adcc_sar_t;

endpackage

//--- adcc_tad_gen.sv
// conversion bit period tick from the system clock or the RC oscillator
`timescale 1ns/100ps
module adcc_tad_gen import adcc_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic run, // count only while converting
    input wire logic [2:0] clkSel, // conversion clock select field
    input wire logic rcOsc, // raw dedicated rc clock
    output logic tadTick // one cycle per bit period
);
    `include "adcc_map.svh"

    adcc_tad_t cur_r;
    adcc_tad_t cur_nxt;
    logic rcSel;
    logic [2:0] divIdx;
    logic [6:0] divTop;

    // ------------------------------------------------------------------
    // divider select: index reorders bits so the ratio doubles per step
    // ------------------------------------------------------------------
    assign rcSel = (clkSel[1:0] == `ADCC_CS_RC);
    assign divIdx = {clkSel[1:0], clkSel[2]};
    assign divTop = (7'h02 << divIdx) - 7'h01;

    // rc edges only count after two flops; the divider restarts idle
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.rcMeta = rcOsc;
        cur_nxt.rcSync = cur_r.rcMeta;
        cur_nxt.rcLast = cur_r.rcSync;
        if (!run || cur_r.cnt == divTop) begin
            cur_nxt.cnt = 7'h00;
        end else begin
            cur_nxt.cnt = cur_r.cnt + 7'h01;
        end
        if (rcSel) begin
            tadTick = run && cur_r.rcSync && !cur_r.rcLast;
        end else begin
            tadTick = run && (cur_r.cnt == divTop);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end
endmodule

//--- adcc_sar.sv
// successive approximation register: one decision per bit period
`timescale 1ns/100ps
module adcc_sar import adcc_pkg::*; #(
    parameter int WIDTH = 10 // result resolution
) (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic start, // begin a conversion
    input wire logic abort, // drop the conversion at once
    input wire logic tadTick, // bit period tick
    input wire logic cmpAbove, // synchronised comparator output
    output logic [WIDTH-1:0] trialCode, // code for the dac
    output logic done, // one cycle, result valid
    output logic [WIDTH-1:0] result // final code, valid with done
);
    adcc_sar_t cur_r;
    adcc_sar_t cur_nxt;
    logic [WIDTH-1:0] decided;

    assign trialCode = cur_r.code;
    // keep the trial bit when the input sits above it
    assign decided = cmpAbove ? cur_r.code : (cur_r.code & ~cur_r.mask);
    assign result = decided;

    // msb first, one bit per tick, 1024 codes in ten steps
    always_comb begin
        cur_nxt = cur_r;
        done = 1'b0;
        if (abort) begin
            cur_nxt = '0;
        end else if (start) begin
            cur_nxt.busy = 1'b1;
            cur_nxt.mask = {1'b1, {(WIDTH-1){1'b0}}};
            cur_nxt.code = {1'b1, {(WIDTH-1){1'b0}}};
        end else if (cur_r.busy && tadTick) begin
            if (cur_r.mask[0]) begin
                done = 1'b1;
                cur_nxt.busy = 1'b0;
                cur_nxt.code = decided;
            end else begin
                cur_nxt.mask = cur_r.mask >> 1;
                cur_nxt.code = decided | (cur_r.mask >> 1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '0;
        end else begin
            cur_r <= cur_nxt;
        end
    end
endmodule

//--- adcc_core.sv
// converter control: apb registers, start sequencing, sleep and results
//
// Overview of operation
// - Done flag bit 6, enable bit 6, global and peripheral enables bits 7:6.
// - Writing one to the go flag, bit 1 of control 0, with the on bit 0 also set, starts conversion.
// - At completion the go flag clears and both result bytes load.
// - Conversion continues in sleep only on the dedicated rc clock.
// - On rc clock, start waits one instruction cycle after go is set.
// - Enabled completion in sleep wakes; global enable selects the vector.
// - Completion in sleep with interrupt disabled powers down, on bit stays.
// - Sleep on a non-rc clock aborts and powers down, on bit stays.
// - Reset restores registers, stops converter, aborts, keeps results.
// - Result has 1024 codes, ten bits.
// - Clock select picks system divided by 2..64 or the rc oscillator.
`timescale 1ns/100ps
module adcc_core import adcc_pkg::*; (
    input wire logic clk, // 10 MHz system clock
    input wire logic rst_b, // async device reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready, always high
    output logic pslverr, // apb error on unmapped access
    input wire logic sleepActive, // core is executing sleep
    input wire logic rcOsc, // dedicated rc oscillator pin
    input wire logic cmpAbove, // async comparator: input above dac
    output logic [9:0] dacCode, // trial code for the dac
    output logic [2:0] channelSel, // analog channel mux
    output logic refSelHigh, // upper reference select
    output logic refSelLow, // lower reference select
    output logic [7:0] analogPinSel, // analog use of each pin
    output logic trackEnable, // hold cap follows the input
    output logic converterPowered, // analog bias on
    output logic irqRequest, // done flag, all enables set
    output logic wakeRequest, // wake the core from sleep
    output logic vectorRequest // wake goes to the interrupt vector
);
    `include "adcc_map.svh"

    adcc_ctrl_t cur_r;
    adcc_ctrl_t cur_nxt;
    adcc_result_t res_r;
    adcc_result_t res_nxt;
    logic [9:0] regIdx;
    logic aligned;
    logic mapped;
    logic wrEn;
    logic sarStart;
    logic sarAbort;
    logic sarDone;
    logic [9:0] sarResult;
    logic tadTick;
    logic rcSel;
    logic doneEv;
    logic goKeep;
    logic goW;
    logic onW;
    logic [7:0] rdByte;

    // ------------------------------------------------------------------
    // apb decode: zero wait states, one word per register
    // ------------------------------------------------------------------
    assign regIdx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'b00);
    assign mapped = aligned && (regIdx == `ADCC_IDX_RES_HIGH
        || regIdx == `ADCC_IDX_CTRL0 || regIdx == `ADCC_IDX_PIN_SEL
        || regIdx == `ADCC_IDX_RES_LOW || regIdx == `ADCC_IDX_CTRL1
        || regIdx == `ADCC_IDX_PFLAG || regIdx == `ADCC_IDX_PEN
        || regIdx == `ADCC_IDX_ICTL);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wrEn = psel && penable && pwrite && mapped;
    assign rcSel = (cur_r.clkSel[1:0] == `ADCC_CS_RC);

    // read mux; bits of other peripherals read as zero
    always_comb begin
        rdByte = 8'h00;
        if (regIdx == `ADCC_IDX_RES_HIGH) begin
            rdByte = res_r.high;
        end else if (regIdx == `ADCC_IDX_CTRL0) begin
            rdByte = cur_r.ctrl0;
        end else if (regIdx == `ADCC_IDX_PIN_SEL) begin
            rdByte = cur_r.pinSel;
        end else if (regIdx == `ADCC_IDX_RES_LOW) begin
            rdByte = res_r.low;
        end else if (regIdx == `ADCC_IDX_CTRL1) begin
            rdByte[`ADCC_C1_CS_HI:`ADCC_C1_CS_LO] = cur_r.clkSel;
        end else if (regIdx == `ADCC_IDX_PFLAG) begin
            rdByte[`ADCC_PF_DONE] = cur_r.doneFlag;
        end else if (regIdx == `ADCC_IDX_PEN) begin
            rdByte[`ADCC_PE_DONE] = cur_r.irqEn;
        end else if (regIdx == `ADCC_IDX_ICTL) begin
            rdByte[`ADCC_IC_GIE] = cur_r.global_irq_enable;
            rdByte[`ADCC_IC_PERIPHERAL_IRQ_ENABLE] = cur_r.peripheral_irq_enable;
        end
        prdata = (psel && aligned) ? {24'h000000, rdByte} : 32'h00000000;
    end

    // ------------------------------------------------------------------
    // sequencer, register writes and sleep handling
    // ------------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        res_nxt = res_r;
        sarStart = 1'b0;
        sarAbort = 1'b0;
        doneEv = 1'b0;
        goW = pwdata[`ADCC_C0_GO];
        onW = pwdata[`ADCC_C0_ON];
        cur_nxt.cmpMeta = cmpAbove;
        cur_nxt.cmpSync = cur_r.cmpMeta;
        unique case (cur_r.state)
            ADCC_IDLE: begin
            end
            ADCC_HOLD: begin
                // lets the sleep instruction run before switching noise
                if (cur_r.hold == 3'h1) begin
                    cur_nxt.state = ADCC_CONV;
                    sarStart = 1'b1;
                end else begin
                    cur_nxt.hold = cur_r.hold - 3'h1;
                end
            end
            ADCC_CONV: begin
                if (sleepActive && !rcSel) begin
                    cur_nxt.state = ADCC_IDLE;
                    cur_nxt.ctrl0[`ADCC_C0_GO] = 1'b0;
                    sarAbort = 1'b1;
                end else if (sarDone) begin
                    cur_nxt.state = ADCC_IDLE;
                    cur_nxt.ctrl0[`ADCC_C0_GO] = 1'b0;
                    doneEv = 1'b1;
                    if (cur_r.ctrl0[`ADCC_C0_FMT]) begin
                        res_nxt.high = {`ADCC_RIGHT_PAD, sarResult[9:8]};
                        res_nxt.low = sarResult[7:0];
                    end else begin
                        res_nxt.high = sarResult[9:2];
                        res_nxt.low = {sarResult[1:0], `ADCC_LEFT_PAD};
                    end
                    if (sleepActive && !cur_r.irqEn) begin
                        cur_nxt.powerDown = 1'b1;
                    end
                end
            end
        endcase
        goKeep = cur_nxt.ctrl0[`ADCC_C0_GO];
        // sleep on a system-derived clock turns the analog part off
        if (sleepActive && !rcSel) begin
            cur_nxt.powerDown = 1'b1;
        end else if (!sleepActive) begin
            cur_nxt.powerDown = 1'b0;
        end
        if (wrEn) begin
            if (regIdx == `ADCC_IDX_CTRL0) begin
                cur_nxt.ctrl0 = pwdata[7:0];
                if (cur_r.state == ADCC_IDLE) begin
                    cur_nxt.ctrl0[`ADCC_C0_GO] = goW && onW;
                    if (goW && onW && rcSel) begin
                        cur_nxt.state = ADCC_HOLD;
                        cur_nxt.hold = 3'(`ADCC_INSTR_CLKS);
                    end else if (goW && onW) begin
                        cur_nxt.state = ADCC_CONV;
                        sarStart = 1'b1;
                    end
                end else begin
                    // clearing go or on mid-conversion abandons it
                    cur_nxt.ctrl0[`ADCC_C0_GO] = goKeep && goW && onW;
                    if (goKeep && !(goW && onW)) begin
                        cur_nxt.state = ADCC_IDLE;
                        sarAbort = 1'b1;
                    end
                end
            end else if (regIdx == `ADCC_IDX_CTRL1) begin
                cur_nxt.clkSel = pwdata[`ADCC_C1_CS_HI:`ADCC_C1_CS_LO];
            end else if (regIdx == `ADCC_IDX_PIN_SEL) begin
                cur_nxt.pinSel = pwdata[7:0];
            end else if (regIdx == `ADCC_IDX_RES_HIGH) begin
                res_nxt.high = pwdata[7:0];
            end else if (regIdx == `ADCC_IDX_RES_LOW) begin
                res_nxt.low = pwdata[7:0];
            end else if (regIdx == `ADCC_IDX_PFLAG) begin
                cur_nxt.doneFlag = pwdata[`ADCC_PF_DONE];
            end else if (regIdx == `ADCC_IDX_PEN) begin
                cur_nxt.irqEn = pwdata[`ADCC_PE_DONE];
            end else if (regIdx == `ADCC_IDX_ICTL) begin
                cur_nxt.global_irq_enable = pwdata[`ADCC_IC_GIE];
                cur_nxt.peripheral_irq_enable = pwdata[`ADCC_IC_PERIPHERAL_IRQ_ENABLE];
            end
        end
        // completion beats a software clear in the same cycle
        if (doneEv) begin
            cur_nxt.doneFlag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state registers; results survive reset on purpose
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '{state: ADCC_IDLE, ctrl0: `ADCC_C0_RST,
                clkSel: `ADCC_C1_RST, pinSel: `ADCC_PIN_SEL_RST,
                default: '0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // no reset branch: a device reset leaves the result bytes unchanged
    always_ff @(posedge clk) begin
        res_r <= res_nxt;
    end

    // ------------------------------------------------------------------
    // conversion clock and approximation datapath
    // ------------------------------------------------------------------
    adcc_tad_gen u_tad (
        .clk(clk),
        .rst_b(rst_b),
        .run(cur_r.state == ADCC_CONV),
        .clkSel(cur_r.clkSel),
        .rcOsc(rcOsc),
        .tadTick(tadTick)
    );

    adcc_sar #(.WIDTH(`ADCC_RES_BITS)) u_sar (
        .clk(clk),
        .rst_b(rst_b),
        .start(sarStart),
        .abort(sarAbort),
        .tadTick(tadTick),
        .cmpAbove(cur_r.cmpSync),
        .trialCode(dacCode),
        .done(sarDone),
        .result(sarResult)
    );

    // ------------------------------------------------------------------
    // analog controls and wake/interrupt requests
    // ------------------------------------------------------------------
    assign channelSel = cur_r.ctrl0[`ADCC_C0_CHS_HI:`ADCC_C0_CHS_LO];
    assign refSelHigh = cur_r.ctrl0[`ADCC_C0_REFH];
    assign refSelLow = cur_r.ctrl0[`ADCC_C0_REFL];
    assign analogPinSel = cur_r.pinSel;
    // on bit keeps reading set while the analog part is shut down
    assign converterPowered = cur_r.ctrl0[`ADCC_C0_ON] && !cur_r.powerDown;
    assign trackEnable = converterPowered && (cur_r.state == ADCC_IDLE);
    assign irqRequest = cur_r.doneFlag && cur_r.irqEn && cur_r.peripheral_irq_enable
        && cur_r.global_irq_enable;
    assign wakeRequest = sleepActive && cur_r.doneFlag && cur_r.irqEn;
    assign vectorRequest = wakeRequest && cur_r.global_irq_enable;
endmodule

//--- adcc_core_props.sv
// assertions on the converter control ports
`timescale 1ns/100ps
module adcc_core_props import adcc_pkg::*; (
    input wire logic clk, // system clock
    input wire logic rst_b, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [31:0] prdata, // apb read data
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic sleepActive, // core sleeping
    input wire logic [9:0] dacCode, // trial code
    input wire logic [2:0] channelSel, // channel mux
    input wire logic refSelHigh, // upper reference
    input wire logic refSelLow, // lower reference
    input wire logic [7:0] analogPinSel, // analog pins
    input wire logic trackEnable, // powered and idle
    input wire logic converterPowered, // analog bias on
    input wire logic irqRequest, // interrupt request
    input wire logic wakeRequest, // wake from sleep
    input wire logic vectorRequest // wake to the vector
);
    // mirror of the rc choice, which alone delays the start
    logic rcSel_r;
    logic wr;
    assign wr = psel && penable && pwrite;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rcSel_r <= 1'b0;
        end else if (wr && paddr == 12'h27C) begin
            rcSel_r <= (pwdata[5:4] == 2'b11);
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    a_ready_high: assert property (psel && penable |-> pready)
        else $error("ready low");
    a_bad_addr: assert property (psel && penable
        && !(paddr inside {12'h078, 12'h07C, 12'h244, 12'h278, 12'h27C,
        12'h030, 12'h230, 12'h02C}) |-> pslverr && prdata == 32'h0)
        else $error("unmapped");
    a_pin_write: assert property (wr && paddr == 12'h244
        |=> analogPinSel == $past(pwdata[7:0])) else $error("pin select");
    a_chan_write: assert property (wr && paddr == 12'h07C
        |=> channelSel == $past(pwdata[4:2]) && refSelHigh == $past(pwdata[6])
        && refSelLow == $past(pwdata[5])) else $error("channel or ref");
    a_go_start: assert property (wr && paddr == 12'h07C && !rcSel_r
        && pwdata[1:0] == 2'b11 && trackEnable
        |=> dacCode == 10'h200 && !trackEnable) else $error("no start");
    a_rc_hold: assert property (wr && paddr == 12'h07C && rcSel_r
        && pwdata[1:0] == 2'b11 && trackEnable
        |-> ##1 $stable(dacCode)[*2]) else $error("rc start early");
    a_conv_ends: assert property ($fell(trackEnable)
        |-> ##[1:700] (trackEnable || !converterPowered))
        else $error("no end");
    a_sleep_abort: assert property (sleepActive && !rcSel_r
        && converterPowered && !trackEnable |-> ##[1:2] !converterPowered)
        else $error("no sleep abort");
    a_wake_vec: assert property (vectorRequest
        |-> wakeRequest && sleepActive) else $error("stray vector");
    a_irq_wake: assert property (irqRequest && sleepActive
        |-> wakeRequest) else $error("no wake");
    a_rst_state: assert property ($rose(rst_b) |-> !converterPowered
        && analogPinSel == 8'hFF && !irqRequest) else $error("reset state");
    c_start: cover property (wr && paddr == 12'h07C && pwdata[1:0] == 2'b11);
    c_wake: cover property (vectorRequest);
    c_sleep_off: cover property ($fell(converterPowered) && sleepActive);
endmodule
bind adcc_core adcc_core_props u_props (.clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleepActive,
    .dacCode, .channelSel, .refSelHigh, .refSelLow, .analogPinSel,
    .trackEnable, .converterPowered, .irqRequest, .wakeRequest,
    .vectorRequest);

//--- adcc_analog_model.sv
// analog side: comparator against a set level and the rc oscillator
`timescale 1ns/100ps
module adcc_analog_model (
    input wire logic [9:0] dacCode, // trial code from the converter
    input wire logic [9:0] level, // input sits half a step above this
    output logic cmpAbove, // comparator decision
    output logic rcOsc // free running rc clock
);
    // half-step offset keeps both readings of above in agreement
    assign cmpAbove = (level >= dacCode);
    // internal oscillator runs free, unrelated to the system clock
    initial begin
        rcOsc = 1'b0;
        forever #1030 rcOsc = ~rcOsc;
    end
endmodule

//--- adcc_core_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adcc_core_bench;
    logic clk, rst_b, psel, penable, pwrite, sleepActive, pready, pslverr;
    logic rcOsc, cmpAbove, err, refSelHigh, refSelLow, trackEnable;
    logic converterPowered, irqRequest, wakeRequest, vectorRequest;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] dacCode, level;
    logic [2:0] channelSel;
    logic [7:0] analogPinSel, c0;
    logic [15:0] expRes;
    int badCount, totalChecks, n;
    logic [2:0] codes [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    logic [9:0] lv [6] = '{10'h3FF, 10'h000, 10'h2A5, 10'h15A, 10'h201,
        10'h1FE};
    adcc_core u_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .sleepActive, .rcOsc, .cmpAbove,
        .dacCode, .channelSel, .refSelHigh, .refSelLow, .analogPinSel,
        .trackEnable, .converterPowered, .irqRequest, .wakeRequest,
        .vectorRequest);
    adcc_analog_model u_ana (.dacCode, .level, .cmpAbove, .rcOsc);
    always #50 clk = ~clk;
    // shared tasks
    task automatic check(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        totalChecks++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            badCount++;
        end
    endtask
    task automatic testDone();
        if (badCount == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one apb transfer; waits for ready, the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [11:0] a,
            input logic [7:0] exp);
        apb(1'b0, a, 8'h00);
        check(what, {24'h0, exp}, rd);
    endtask
    // result placement worked out from the format bit
    task automatic resChk(input logic [9:0] v, input logic f);
        expRes = f ? {6'h00, v} : {v, 6'h00};
        rdchk("result high", 12'h078, expRes[15:8]);
        rdchk("result low", 12'h278, expRes[7:0]);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        testDone();
    end
    // main sequence
    initial begin
        {clk, rst_b, psel, penable, pwrite, sleepActive} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        level = 10'h000;
        badCount = 0;
        totalChecks = 0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, 12'h100, 8'h00);
        check("unmapped err", 32'h1, 32'(err));
        check("unmapped data", 32'h0, rd);
        apb(1'b1, 12'h07F, 8'h03);
        check("unaligned err", 32'h1, 32'(err));
        apb(1'b1, 12'h07C, 8'h02);
        rdchk("go while off", 12'h07C, 8'h00);
        for (int i = 0; i < 6; i++) begin
            level <= lv[i];
            c0 = {i[0], 2'b01, i[2:0], 2'b01};
            apb(1'b1, 12'h244, 8'h01 << i);
            apb(1'b1, 12'h27C, {1'b0, codes[i], 4'h0});
            apb(1'b1, 12'h07C, c0);
            repeat (20) @(posedge clk);
            check("channel", 32'(i[2:0]), 32'(channelSel));
            apb(1'b1, 12'h07C, c0 | 8'h02);
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (trackEnable !== 1'b1 && n < 2000);
            check("conv time", 32'h1,
                32'(n >= 9 * (2 << i) + 1 && n <= 10 * (2 << i) + 4));
            rdchk("go cleared", 12'h07C, c0);
            rdchk("done flag", 12'h030, 8'h40);
            resChk(lv[i], i[0]);
            apb(1'b1, 12'h030, 8'h00);
            repeat (2 * (2 << i)) @(posedge clk);
        end
        // rc clock in sleep, interrupt off: finishes, then powers down
        apb(1'b1, 12'h27C, 8'h30);
        level <= 10'h0C3;
        apb(1'b1, 12'h07C, 8'h03);
        sleepActive <= 1'b1;
        n = 0;
        do begin
            apb(1'b0, 12'h07C, 8'h00);
            n++;
        end while (rd[1] !== 1'b0 && n < 200);
        check("on bit kept", 32'h1, rd);
        check("rc sleep off", 32'h0, 32'(converterPowered));
        resChk(10'h0C3, 1'b0);
        sleepActive <= 1'b0;
        apb(1'b1, 12'h030, 8'h00);
        // rc clock in sleep, interrupt on: wakes to the vector
        apb(1'b1, 12'h230, 8'h40);
        apb(1'b1, 12'h02C, 8'hC0);
        level <= 10'h2E7;
        apb(1'b1, 12'h07C, 8'h83);
        sleepActive <= 1'b1;
        n = 0;
        while (wakeRequest !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("wake", 32'h1, 32'(wakeRequest));
        check("vector", 32'h1, 32'(vectorRequest));
        check("irq", 32'h1, 32'(irqRequest));
        apb(1'b1, 12'h02C, 8'h40);
        @(negedge clk);
        check("no vector", 32'h0, 32'(vectorRequest));
        check("wake kept", 32'h1, 32'(wakeRequest));
        resChk(10'h2E7, 1'b1);
        sleepActive <= 1'b0;
        apb(1'b1, 12'h030, 8'h00);
        @(negedge clk);
        check("irq cleared", 32'h0, 32'(irqRequest));
        // sleep on a divided clock aborts the conversion
        apb(1'b1, 12'h27C, 8'h60);
        apb(1'b1, 12'h07C, 8'h03);
        repeat (30) @(posedge clk);
        sleepActive <= 1'b1;
        repeat (3) @(posedge clk);
        check("abort off", 32'h0, 32'(converterPowered));
        rdchk("abort go", 12'h07C, 8'h01);
        rdchk("abort no done", 12'h030, 8'h00);
        sleepActive <= 1'b0;
        repeat (2) @(posedge clk);
        check("power back", 32'h1, 32'(converterPowered));
        // device reset mid-conversion keeps the results
        apb(1'b1, 12'h07C, 8'h03);
        repeat (30) @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        check("reset off", 32'h0, 32'(converterPowered));
        rdchk("ctrl0 rst", 12'h07C, 8'h00);
        rdchk("clksel rst", 12'h27C, 8'h00);
        rdchk("pins rst", 12'h244, 8'hFF);
        rdchk("enable rst", 12'h230, 8'h00);
        rdchk("intctl rst", 12'h02C, 8'h00);
        rdchk("res hi kept", 12'h078, expRes[15:8]);
        rdchk("res lo kept", 12'h278, expRes[7:0]);
        testDone();
    end
endmodule
